//--- hdl/lgi_gpio.sv
// Purpose: three general pins shared with link indicators, APB registers
// Assumes: status inputs synchronous to pclk
// Notes: indicator pins are open drain; pin input sampled directly
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`include "lgi_params.svh"
`timescale 1ns/1ps
module lgi_gpio #(
    parameter int BLINK_CYC = `LGI_BLINK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] pin_in,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe,
    input wire logic crossover_auto_strap,
    output logic crossover_auto_en,
    input wire logic link_up,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic activity
);
    logic [31:0] cfg_ff, nxt_cfg;
    logic [2:0] dout_ff, nxt_dout;
    logic [31:0] rdata_ff, nxt_rdata;
    logic ready_ff, nxt_ready;
    logic err_ff, nxt_err;
    logic [2:0] pout_ff, nxt_pout;
    logic [2:0] poe_ff, nxt_poe;
    logic mdix_ff, nxt_mdix;
    logic [2:0] ind_n;
    logic blink_n;
    logic access;

    ////////////////////////////////////////////////////////////////////////
    // link blink sequencer
    lgi_blink #(
        .BLINK_CYC(BLINK_CYC)
    ) u_blink (
        .pclk(pclk),
        .presetn(presetn),
        .link_up(link_up),
        .activity(activity),
        .ind_n(blink_n)
    );

    // indicator levels, high means released
    always_comb
    begin
        ind_n[0] = !(link_up && speed_100);
        ind_n[1] = blink_n;
        ind_n[2] = !(link_up && full_duplex);
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state per access, pready registered
    assign access = psel && penable && !ready_ff;

    always_comb
    begin
        nxt_cfg = cfg_ff;
        nxt_dout = dout_ff;
        nxt_rdata = rdata_ff;
        nxt_ready = 1'b0;
        nxt_err = 1'b0;
        if (access)
        begin
            nxt_ready = 1'b1;
            nxt_rdata = 32'h0;
            case (paddr)
                `LGI_OFF_CFG:
                begin
                    if (pwrite)
                        nxt_cfg = pwdata;
                    else
                        nxt_rdata = cfg_ff;
                end
                `LGI_OFF_OUT:
                begin
                    if (pwrite)
                        nxt_dout = pwdata[2:0];
                    else
                        nxt_rdata = {29'h0, dout_ff};
                end
                `LGI_OFF_IN:
                    nxt_rdata = {29'h0, pin_in};
                `LGI_OFF_STAT:
                    nxt_rdata = {28'h0, mdix_ff, ind_n};
                default:
                    nxt_err = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers, one per pin
    for (genvar i = 0; i < `LGI_NPINS; i++)
    begin : g_pin
        always_comb
        begin
            lgi_pkg::lgi_mode_t mode;
            mode = lgi_pkg::lgi_mode_t'(cfg_ff[`LGI_MODE_LSB + 2 * i +: 2]);
            nxt_pout[i] = 1'b0;
            nxt_poe[i] = 1'b0;
            if (cfg_ff[`LGI_IND_LSB + i])
                nxt_poe[i] = !ind_n[i];
            else if (mode == lgi_pkg::LGI_MODE_PP)
            begin
                nxt_pout[i] = dout_ff[i];
                nxt_poe[i] = 1'b1;
            end
            else if (mode == lgi_pkg::LGI_MODE_OD)
                nxt_poe[i] = !dout_ff[i];
        end
    end

    // strap level registered each pclk, reset loads 1 so crossover starts enabled
    assign nxt_mdix = crossover_auto_strap;

    // registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_ff <= `LGI_CFG_RST;
            dout_ff <= 3'h0;
            rdata_ff <= 32'h0;
            ready_ff <= 1'b0;
            err_ff <= 1'b0;
            pout_ff <= 3'h0;
            poe_ff <= 3'h0;
            mdix_ff <= 1'b1;
        end
        else
        begin
            cfg_ff <= nxt_cfg;
            dout_ff <= nxt_dout;
            rdata_ff <= nxt_rdata;
            ready_ff <= nxt_ready;
            err_ff <= nxt_err;
            pout_ff <= nxt_pout;
            poe_ff <= nxt_poe;
            mdix_ff <= nxt_mdix;
        end
    end

    assign prdata = rdata_ff;
    assign pready = ready_ff;
    assign pslverr = err_ff;
    assign pin_out = pout_ff;
    assign pin_oe = poe_ff;
    assign crossover_auto_en = mdix_ff;
endmodule : lgi_gpio

//--- hdl/lgi_params.svh
// Purpose: constants for the indicator/general pin block
// Assumes: pclk at 25 MHz, registers on an APB slave
// Notes: offsets are byte addresses of 32-bit words
`ifndef LGI_PARAMS_SVH
`define LGI_PARAMS_SVH
`define LGI_CLK_HZ 25000000
`define LGI_BLINK_MS 80
`define LGI_BLINK_CYC ((`LGI_CLK_HZ / 1000) * `LGI_BLINK_MS)
`define LGI_OFF_CFG 12'h000
`define LGI_OFF_OUT 12'h004
`define LGI_OFF_IN 12'h008
`define LGI_OFF_STAT 12'h00c
`define LGI_NPINS 3
`define LGI_CFG_RST 32'h0000_0000
`define LGI_MODE_LSB 0
`define LGI_IND_LSB 8
`endif

//--- hdl/lgi_pkg.sv
// Purpose: types for the indicator/general pin block
// Assumes: included constants in lgi_params.svh
// Notes: pin mode encoding per two-bit field
package lgi_pkg;
    typedef enum logic [1:0]
    {
        LGI_MODE_IN = 2'h0,
        LGI_MODE_PP = 2'h1,
        LGI_MODE_OD = 2'h2
    } lgi_mode_t;
    typedef enum logic [1:0]
    {
        LGI_ON,
        LGI_OFF_PULSE,
        LGI_HOLD_ON
    } lgi_blink_t;
endpackage : lgi_pkg

//--- hdl/lgi_blink.sv
// Purpose: link and activity blink sequencer
// Assumes: link and activity synchronous to pclk
// Notes: output high means indicator unlit
`include "lgi_params.svh"
`timescale 1ns/1ps
module lgi_blink #(
    parameter int BLINK_CYC = `LGI_BLINK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic link_up,
    input wire logic activity,
    output logic ind_n
);
    lgi_pkg::lgi_blink_t state_ff, nxt_state;
    logic [31:0] cnt_ff, nxt_cnt;
    logic ind_ff, nxt_ind;
    localparam logic [31:0] LAST = 32'(BLINK_CYC - 1);

    // sequence: lit, off pulse, forced lit gap
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            lgi_pkg::LGI_ON:
            begin
                nxt_cnt = 32'h0;
                if (link_up && activity)
                    nxt_state = lgi_pkg::LGI_OFF_PULSE;
            end
            lgi_pkg::LGI_OFF_PULSE:
            begin
                nxt_cnt = cnt_ff + 32'h1;
                if (cnt_ff == LAST)
                begin
                    nxt_state = lgi_pkg::LGI_HOLD_ON;
                    nxt_cnt = 32'h0;
                end
            end
            lgi_pkg::LGI_HOLD_ON:
            begin
                nxt_cnt = cnt_ff + 32'h1;
                // gap over: pulse again at once if traffic is still present
                if (cnt_ff == LAST)
                begin
                    nxt_cnt = 32'h0;
                    if (link_up && activity)
                        nxt_state = lgi_pkg::LGI_OFF_PULSE;
                    else
                        nxt_state = lgi_pkg::LGI_ON;
                end
            end
            default:
            begin
                nxt_state = lgi_pkg::LGI_ON;
                nxt_cnt = 32'h0;
            end
        endcase
        if (!link_up)
        begin
            nxt_state = lgi_pkg::LGI_ON;
            nxt_cnt = 32'h0;
        end
        nxt_ind = !(link_up && nxt_state != lgi_pkg::LGI_OFF_PULSE);
    end

    // registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= lgi_pkg::LGI_ON;
            cnt_ff <= 32'h0;
            ind_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            ind_ff <= nxt_ind;
        end
    end

    assign ind_n = ind_ff;
endmodule : lgi_blink

//--- dv/lgi_chk.sv
// Purpose: port checker for lgi_gpio
// Assumes: config tracked from APB writes
// Notes: blink timing kept in counters
`include "lgi_params.svh"
`timescale 1ns/1ps
module lgi_chk #(
    parameter int BLINK_CYC = 10
) (
    input wire logic pclk, presetn, psel, penable, pwrite, pready,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [2:0] pin_out, pin_oe,
    input wire logic crossover_auto_strap, crossover_auto_en,
    input wire logic link_up, speed_100, full_duplex, activity
);
    logic [10:0] cfg_ff, nxt_cfg;
    int off_ff, on_ff, nxt_off, nxt_on;
    logic hit_ff, nxt_hit;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // config shadow and unlit/lit run lengths of pin 1
    always_comb
    begin
        nxt_cfg = (psel && penable && pready && pwrite && paddr == `LGI_OFF_CFG) ?
            pwdata[10:0] : cfg_ff;
        nxt_off = (cfg_ff[9] && link_up && !pin_oe[1]) ? off_ff + 1 : 0;
        nxt_on = pin_oe[1] ? on_ff + 1 : 0;
        nxt_hit = cfg_ff[9] && link_up && (hit_ff || (pin_oe[1] && off_ff > 2));
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_ff <= '0;
            off_ff <= 0;
            on_ff <= 0;
            hit_ff <= 1'b0;
        end
        else
        begin
            cfg_ff <= nxt_cfg;
            off_ff <= nxt_off;
            on_ff <= nxt_on;
            hit_ff <= nxt_hit;
        end
    end
    a_xover_follow: assert property (1 |=> crossover_auto_en == $past(crossover_auto_strap))
        else $error("crossover enable does not follow strap");
    a_mode_pp: assert property (!cfg_ff[8] && cfg_ff[1:0] == 2'h1 |-> pin_oe[0])
        else $error("push-pull pin not driven");
    a_ind_od: assert property (1 |=> ($past(cfg_ff[10:8]) & pin_oe & pin_out) == 3'h0)
        else $error("indicator pin driven high");
    a_speed_ind: assert property (cfg_ff[8] |=>
        (pin_oe[0] && !pin_out[0]) == $past(link_up && speed_100))
        else $error("speed indicator wrong");
    a_link_lit: assert property ($rose(link_up) && !activity && cfg_ff[9] |-> ##2
        pin_oe[1] && !pin_out[1]) else $error("link indicator not lit");
    a_blink_off: assert property ($rose(pin_oe[1]) && off_ff > 2 |-> off_ff == BLINK_CYC)
        else $error("off pulse length wrong");
    a_blink_gap: assert property ($fell(pin_oe[1]) && hit_ff && link_up && $past(link_up)
        |-> on_ff >= BLINK_CYC) else $error("lit gap too short");
    a_dup_ind: assert property (cfg_ff[10] |=>
        (pin_oe[2] && !pin_out[2]) == $past(link_up && full_duplex))
        else $error("duplex indicator wrong");
    a_rst_rel: assert property (disable iff (1'b0) !presetn |-> pin_oe == 3'h0)
        else $error("pins driven in reset");
endmodule : lgi_chk

//--- dv/lgi_board.sv
// Purpose: board side of the three pins
// Assumes: every pin has a pull-up
// Notes: ext_en lets the bench sink a pin low
`timescale 1ns/1ps
module lgi_board (
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] ext_en,
    input wire logic [2:0] ext_val,
    output logic [2:0] pin_in
);
    // any sink wins, else driven high or pulled up
    assign pin_in = ~((pin_oe & ~pin_out) | (ext_en & ~ext_val));
endmodule : lgi_board

//--- dv/tb.sv
// Purpose: testbench for lgi_gpio
// Assumes: BLINK_CYC set to 10
// Notes: APB master tasks, pins seen through board model
`include "lgi_params.svh"
`timescale 1ns/1ps
module tb;
    logic pclk, presetn = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic crossover_auto_strap = 1, crossover_auto_en;
    logic link_up = 0, speed_100 = 0, full_duplex = 0, activity = 0;
    logic [2:0] pin_in, pin_out, pin_oe, ext_en = 0, ext_val = 0;
    int errors = 0, checks = 0, n;
    lgi_gpio #(.BLINK_CYC(10)) dut_u (.*);
    lgi_board brd_u (.*);
    ////////////////////////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask : cyc
    // one APB transfer, then two edges for the pins to follow
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        cyc(2);
    endtask : xfer
    task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask : chk
    // counts cycles pin 1 stays at v
    task automatic run(input logic v);
        n = 0;
        while (pin_in[1] === v)
        begin
            n++;
            @(posedge pclk);
        end
    endtask : run
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    initial
    begin
        #400000;
        errors++;
        end_of_test;
    end
    initial
    begin
        presetn <= 1'b0; // falls after all processes start, so the reset edge is seen
        cyc(16);
        presetn <= 1'b1;
        cyc(1);
        chk("oe", pin_oe, 0);
        xfer(0, `LGI_OFF_CFG, 0);
        chk("cfg", rd, `LGI_CFG_RST);
        crossover_auto_strap <= 1'b0;
        xfer(0, `LGI_OFF_STAT, 0);
        chk("xover", crossover_auto_en, 0);
        $display("test strap done");
        for (int i = 0; i < 3; i++)
        begin
            for (int m = 1; m < 3; m++)
            begin
                xfer(1, `LGI_OFF_CFG, m << (2 * i));
                xfer(1, `LGI_OFF_OUT, 0);
                chk("low", pin_in[i], 0);
                xfer(1, `LGI_OFF_OUT, 7);
                chk("high", pin_in[i], 1);
                chk("oe", pin_oe[i], m == 1);
            end
            ext_en[i] <= 1'b1;
            xfer(1, `LGI_OFF_CFG, 0);
            xfer(0, `LGI_OFF_IN, 0);
            chk("in", rd[i], 0);
            ext_en[i] <= 1'b0;
        end
        xfer(0, 12'h010, 0);
        chk("err", er, 1);
        $display("test modes done");
        xfer(1, `LGI_OFF_CFG, 32'h700);
        link_up <= 1'b1;
        speed_100 <= 1'b1;
        full_duplex <= 1'b1;
        cyc(3);
        chk("lit", pin_in, 0);
        chk("od", pin_oe & pin_out, 0);
        speed_100 <= 1'b0;
        full_duplex <= 1'b0;
        cyc(3);
        chk("unlit", pin_in, 3'h5);
        activity <= 1'b1;
        while (pin_in[1] !== 1'b1) @(posedge pclk);
        run(1);
        chk("off", n, 10);
        run(0);
        chk("gap", n, 10);
        activity <= 1'b0;
        cyc(30);
        presetn <= 1'b0;
        cyc(2);
        chk("rst", pin_oe, 0);
        $display("test indicators done");
        end_of_test;
    end
endmodule : tb

bind lgi_gpio lgi_chk #(.BLINK_CYC(BLINK_CYC)) chk_u (.*);
